// ===== core/adrg_map.svh
// Named constants of the auto dialer retry guard: offsets, fields, times.
// Assumes inclusion by bare name from the design and bench files of this block.
`ifndef ADRG_MAP_SVH
`define ADRG_MAP_SVH
// Register byte offsets on the AXI4-Lite bus.
`define ADRG_AW 8
`define ADRG_OFF_CTRL 8'h00
`define ADRG_OFF_STATUS 8'h04
`define ADRG_OFF_IRQ_STAT 8'h08
`define ADRG_OFF_IRQ_MASK 8'h0c
// Control register fields.
`define ADRG_C_START 0
`define ADRG_C_REACT 1
`define ADRG_C_MANUAL 2
`define ADRG_C_EXEMPT 3
`define ADRG_C_TONE_CAP 4
`define ADRG_C_DT_CAP 5
`define ADRG_C_GS_LINE 6
`define ADRG_C_SEQ 7
`define ADRG_C_NEXT 8
`define ADRG_C_HANG 9
`define ADRG_CTRL_KEEP 32'h0000_00fc
`define ADRG_CTRL_RST 32'h0000_0000
// Interrupt bits, shared by status and mask.
`define ADRG_I_FAIL 0
`define ADRG_I_LOCK 1
`define ADRG_I_ANSWER 2
`define ADRG_I_REFUSE 3
`define ADRG_IRQ_W 4
// Bus responses.
`define ADRG_RESP_OKAY 2'b00
`define ADRG_RESP_SLVERR 2'b10
// Attempt limits.
`define ADRG_BASE_LIMIT 4'h2
`define ADRG_EXT_LIMIT 4'hf
// Clock and times in their own units.
`define ADRG_CLK_HZ 20000000
`define ADRG_MS_PER_S 1000
`define ADRG_S_PER_MIN 60
`define ADRG_LOCK_MIN 60
`define ADRG_NOANS_S 60
`define ADRG_DT_GAP_MS 70
`define ADRG_GS_GAP_MS 70
`define ADRG_OFFHOOK_MS 600
`endif

// ===== core/adrg_pkg.sv
// Types and helpers shared by the auto dialer retry guard files.
// Assumes it is compiled before every module of the block.
package adrg_pkg;

  // Call progress states, one-hot.
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_WAIT = 6'h02,
    ST_PRE = 6'h04,
    ST_DIAL = 6'h08,
    ST_RING = 6'h10,
    ST_CONN = 6'h20
  } adrg_state_t;

  // Expands AXI byte strobes into a bit mask.
  function automatic logic [31:0] adrg_strb_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

endpackage

// ===== core/adrg_tick.sv
// Restartable millisecond prescaler for the auto dialer retry guard.
// Assumes one clock; clr held high keeps the phase at zero.
`timescale 1ns/1ps
module adrg_tick #(
  parameter int CYCLES = 20000
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Phase restart and tick out.
  input wire logic clr,
  output logic tick
);
  localparam int W = $clog2(CYCLES + 1);
  logic [W-1:0] cnt;

  // A tick lands exactly CYCLES edges after clr, so whole ticks never
  // overcount the elapsed time.
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      cnt <= '0;
      tick <= 1'b0;
    end else if (cnt == W'(CYCLES - 1)) begin
      cnt <= '0;
      tick <= 1'b1;
    end else begin
      cnt <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule

// ===== core/adrg_axil.sv
// AXI4-Lite slave front end for the auto dialer retry guard.
// Assumes the register side decodes addresses and answers combinationally.
`timescale 1ns/1ps
`include "adrg_map.svh"
module adrg_axil import adrg_pkg::*; (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write channels.
  input wire logic [`ADRG_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // Read channels.
  input wire logic [`ADRG_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register side.
  output logic wr_en,
  output logic [`ADRG_AW-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_hit,
  output logic [`ADRG_AW-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_hit
);
  logic aw_done;
  logic w_done;

  // Address and data are accepted in either order, one write at a time.
  assign awready = !aw_done && !bvalid;
  assign wready = !w_done && !bvalid;
  assign wr_en = aw_done && w_done && !bvalid;
  assign arready = !rvalid;
  assign rd_addr = araddr;

  // Write address and data capture.
  always_ff @(posedge aclk) begin
    if (!aresetn || wr_en) begin
      aw_done <= 1'b0;
      w_done <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_done <= 1'b1;
      end
      if (wvalid && wready) begin
        w_done <= 1'b1;
      end
    end
  end

  // Payload latches.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else begin
      if (awvalid && awready) begin
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
    end
  end

  // Write response; unmapped offsets answer with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `ADRG_RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_hit ? `ADRG_RESP_OKAY : `ADRG_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read data is sampled at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `ADRG_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata <= rd_hit ? rd_data : '0;
      rresp <= rd_hit ? `ADRG_RESP_OKAY : `ADRG_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule

// ===== core/adrg_top.sv
// Auto dialer retry guard: call sequencer, attempt limits and lockout.
// Assumes line detector inputs are synchronous to aclk and static config.
//
// Chosen here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`include "adrg_map.svh"
module adrg_top import adrg_pkg::*; #(
  parameter int MS_CYCLES = `ADRG_CLK_HZ / `ADRG_MS_PER_S,
  parameter int LOCK_MS = `ADRG_LOCK_MIN * `ADRG_S_PER_MIN * `ADRG_MS_PER_S,
  parameter int NOANS_MS = `ADRG_NOANS_S * `ADRG_MS_PER_S
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [`ADRG_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [`ADRG_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Line side detectors.
  input wire logic dial_tone,
  input wire logic gs_ind,
  input wire logic busy_det,
  input wire logic reorder_det,
  input wire logic answer_det,
  input wire logic compat_det,
  input wire logic digits_done,
  input wire logic hangup_note,
  input wire logic ext_reactivate,
  // Line controls and interrupt.
  output logic off_hook,
  output logic addr_en,
  output logic irq
);
  adrg_state_t state, next_state;
  logic wr_en, wr_hit, rd_hit;
  logic [`ADRG_AW-1:0] wr_addr, rd_addr;
  logic [31:0] wr_data, rd_data, wmask, wmd, ctrl;
  logic [3:0] wr_strb, cnt, cnt_inc;
  logic [`ADRG_IRQ_W-1:0] irq_stat, irq_mask, irq_set;
  logic [15:0] ms_cnt;
  logic [21:0] lock_ms;
  logic ms_tick, lock_tick, tick_clr, locked, lock_set, lock_done;
  logic all_tone, inc_cnt, inc_block, seq_once;
  logic wr_ctrl, start_req, clear_req, hang_req, start_ok, bypass;
  logic tone_in, ev_fail, ev_tone, ev_answer;

  // Millisecond counts and limits taken from the millisecond figures.
  localparam logic [15:0] NOANS_LAST = 16'(NOANS_MS - 1);
  localparam logic [15:0] DT_GAP = 16'(`ADRG_DT_GAP_MS);
  localparam logic [15:0] GS_GAP = 16'(`ADRG_GS_GAP_MS);
  localparam logic [15:0] OFFHOOK_GAP = 16'(`ADRG_OFFHOOK_MS);
  localparam logic [21:0] LOCK_LAST = 22'(LOCK_MS - 1);

  adrg_axil u_axil (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
    .wr_strb(wr_strb), .wr_hit(wr_hit),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_hit(rd_hit)
  );

  // Call timer restarts at every state change; lock timer while unlocked.
  adrg_tick #(.CYCLES(MS_CYCLES)) u_call_tick (
    .aclk(aclk), .aresetn(aresetn), .clr(tick_clr), .tick(ms_tick)
  );
  adrg_tick #(.CYCLES(MS_CYCLES)) u_lock_tick (
    .aclk(aclk), .aresetn(aresetn), .clr(!locked), .tick(lock_tick)
  );

  // Write decode with byte strobes; pulse bits are never stored.
  assign wmask = adrg_strb_mask(wr_strb);
  assign wmd = wr_data & wmask;
  assign wr_ctrl = wr_en && wr_addr == `ADRG_OFF_CTRL;
  assign start_req = wr_ctrl && wmd[`ADRG_C_START];
  assign hang_req = wr_ctrl && wmd[`ADRG_C_HANG];
  assign clear_req = (wr_ctrl && (wmd[`ADRG_C_REACT] || wmd[`ADRG_C_NEXT]))
                     || ext_reactivate;
  assign bypass = ctrl[`ADRG_C_MANUAL] || ctrl[`ADRG_C_EXEMPT];
  assign start_ok = start_req && state == ST_IDLE && (bypass ||
    !(locked || inc_block || (ctrl[`ADRG_C_SEQ] && seq_once)));
  assign tone_in = busy_det || reorder_det;
  assign tick_clr = next_state != state || state == ST_IDLE;
  assign cnt_inc = cnt + 4'h1;

  // Call sequencer next state and attempt outcome events.
  always_comb begin
    next_state = state;
    ev_fail = 1'b0;
    ev_tone = 1'b0;
    ev_answer = 1'b0;
    case (state)
      ST_IDLE: begin
        if (start_ok) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (hang_req || ms_cnt == NOANS_LAST) begin
          next_state = ST_IDLE;
          ev_fail = 1'b1;
        end else if (ctrl[`ADRG_C_GS_LINE]) begin
          if (gs_ind) begin
            next_state = ST_PRE;
          end
        end else if (ctrl[`ADRG_C_DT_CAP]) begin
          if (dial_tone) begin
            next_state = ST_PRE;
          end
        end else if (ms_cnt >= OFFHOOK_GAP) begin
          next_state = ST_DIAL;
        end
      end
      ST_PRE: begin
        if (hang_req) begin
          next_state = ST_IDLE;
          ev_fail = 1'b1;
        end else if (ms_cnt >= (ctrl[`ADRG_C_GS_LINE] ? GS_GAP : DT_GAP)) begin
          next_state = ST_DIAL;
        end
      end
      ST_DIAL: begin
        if (hang_req) begin
          next_state = ST_IDLE;
          ev_fail = 1'b1;
        end else if (digits_done) begin
          next_state = ST_RING;
        end
      end
      ST_RING: begin
        if (hang_req || ms_cnt == NOANS_LAST) begin
          next_state = ST_IDLE;
          ev_fail = 1'b1;
        end else if (ctrl[`ADRG_C_TONE_CAP] && tone_in) begin
          next_state = ST_IDLE;
          ev_fail = 1'b1;
          ev_tone = 1'b1;
        end else if (answer_det) begin
          next_state = ST_CONN;
          ev_answer = 1'b1;
        end
      end
      ST_CONN: begin
        if (hangup_note || hang_req) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // State register and registered line controls.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      off_hook <= 1'b0;
      addr_en <= 1'b0;
    end else begin
      state <= next_state;
      off_hook <= next_state != ST_IDLE;
      addr_en <= next_state == ST_DIAL;
    end
  end

  // Millisecond count within the current state.
  always_ff @(posedge aclk) begin
    if (!aresetn || tick_clr) begin
      ms_cnt <= '0;
    end else if (ms_tick && state != ST_CONN && state != ST_DIAL) begin
      ms_cnt <= ms_cnt + 16'h1;
    end
  end

  // The extended limit holds only while every attempt met a tone.
  assign lock_set = !bypass && ev_fail && cnt_inc >=
    ((ctrl[`ADRG_C_TONE_CAP] && all_tone && ev_tone) ?
     `ADRG_EXT_LIMIT : `ADRG_BASE_LIMIT);
  assign lock_done = locked && lock_tick && lock_ms == LOCK_LAST;

  // Successive attempt counting; bypass modes leave it untouched.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_req || lock_done) begin
      cnt <= '0;
      all_tone <= 1'b1;
    end else if (!bypass && ev_fail) begin
      cnt <= cnt_inc;
      all_tone <= all_tone && ev_tone;
    end else if (!bypass && ev_answer) begin
      cnt <= '0;
      all_tone <= 1'b1;
    end
  end

  // Lockout flag and its 60 minute timer.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_req) begin
      locked <= 1'b0;
    end else if (lock_set) begin
      locked <= 1'b1;
    end else if (lock_done) begin
      locked <= 1'b0;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || !locked) begin
      lock_ms <= '0;
    end else if (lock_tick) begin
      lock_ms <= lock_ms + 22'h1;
    end
  end

  // Answers to an incompatible terminal: the second one blocks dialing.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_req) begin
      inc_cnt <= 1'b0;
      inc_block <= 1'b0;
    end else if (!bypass && ev_answer && !compat_det) begin
      inc_block <= inc_cnt;
      inc_cnt <= 1'b1;
    end
  end

  // Sequential mode marks the number as used after one attempt.
  always_ff @(posedge aclk) begin
    if (!aresetn || clear_req) begin
      seq_once <= 1'b0;
    end else if (!bypass && ctrl[`ADRG_C_SEQ] && (ev_fail || ev_answer)) begin
      seq_once <= 1'b1;
    end
  end

  // Control, mask and sticky interrupt registers; a set beats a clear.
  assign irq_set = {start_req && !start_ok, ev_answer, lock_set, ev_fail};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `ADRG_CTRL_RST;
      irq_mask <= '0;
      irq_stat <= '0;
      irq <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= ((ctrl & ~wmask) | wmd) & `ADRG_CTRL_KEEP;
      end
      if (wr_en && wr_addr == `ADRG_OFF_IRQ_MASK) begin
        irq_mask <= (irq_mask & ~wmask[`ADRG_IRQ_W-1:0]) |
                    wmd[`ADRG_IRQ_W-1:0];
      end
      if (wr_en && wr_addr == `ADRG_OFF_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wmd[`ADRG_IRQ_W-1:0]) | irq_set;
      end else begin
        irq_stat <= irq_stat | irq_set;
      end
      irq <= |((irq_stat | irq_set) & irq_mask);
    end
  end

  // Read decode; status shows count, flags and the one-hot state.
  assign wr_hit = wr_addr == `ADRG_OFF_CTRL || wr_addr == `ADRG_OFF_STATUS ||
    wr_addr == `ADRG_OFF_IRQ_STAT || wr_addr == `ADRG_OFF_IRQ_MASK;
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    case (rd_addr)
      `ADRG_OFF_CTRL: rd_data = ctrl;
      `ADRG_OFF_STATUS: rd_data = {18'h0, state, all_tone, seq_once,
                                   inc_block, locked, cnt};
      `ADRG_OFF_IRQ_STAT: rd_data = {28'h0, irq_stat};
      `ADRG_OFF_IRQ_MASK: rd_data = {28'h0, irq_mask};
      default: rd_hit = 1'b0;
    endcase
  end

  // Checks on the guard behaviour.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_hang_seen;
    state == ST_CONN && hangup_note;
  endsequence

  chk_two_max: assert property (
    cnt >= `ADRG_BASE_LIMIT && !all_tone |-> locked)
    else $error("two attempt limit passed without lockout");
  chk_fifteen_max: assert property (cnt == `ADRG_EXT_LIMIT |-> locked)
    else $error("fifteenth attempt without lockout");
  chk_lock_hold: assert property (
    $fell(locked) |-> $past(lock_ms) == LOCK_LAST || $past(clear_req))
    else $error("lockout ended early");
  chk_react_clear: assert property (
    clear_req |=> !locked && cnt == 4'h0 && !inc_block)
    else $error("reactivation did not clear the guard");
  chk_bypass_start: assert property (
    bypass && start_req && state == ST_IDLE |=> state == ST_WAIT ##1 off_hook)
    else $error("bypass mode refused a dial");
  chk_tone_onhook: assert property (
    state == ST_RING && ctrl[`ADRG_C_TONE_CAP] && tone_in && !answer_det
    |=> !off_hook)
    else $error("no on-hook after busy or reorder");
  chk_noans_bound: assert property (state == ST_RING |-> ms_cnt < NOANS_LAST
    or (ms_cnt == NOANS_LAST ##1 !off_hook))
    else $error("ring wait ran past its bound");
  chk_incompat_refuse: assert property (
    start_req && inc_block && !bypass && !clear_req && state == ST_IDLE
    |=> state == ST_IDLE)
    else $error("dial after second incompatible answer");
  chk_seq_once: assert property (
    start_req && seq_once && ctrl[`ADRG_C_SEQ] && !bypass && !clear_req &&
    state == ST_IDLE |=> state == ST_IDLE && irq_stat[`ADRG_I_REFUSE])
    else $error("sequential number dialed twice");
  chk_addr_delay: assert property ($rose(addr_en) |->
    $past(ms_cnt) >= ($past(state) == ST_PRE ? DT_GAP : OFFHOOK_GAP))
    else $error("addressing started too early");
  chk_hang_release: assert property (s_hang_seen |=> ##1 !off_hook)
    else $error("line held after hang-up notice");
endmodule

// ===== testbench/adrg_line.sv
// Behavioural telephone line facing the auto dialer retry guard.
// Assumes off_hook and addr_en come from the dialer on the same clock.
`timescale 1ns/1ps
module adrg_line (
  // Clock.
  input wire logic aclk,
  // Dialer side.
  input wire logic off_hook,
  input wire logic addr_en,
  // Outcome: 0 busy, 1 compatible, 2 incompatible, 3 silent, 4 reorder.
  input wire logic [2:0] mode,
  // Detector outputs.
  output logic dial_tone,
  output logic gs_ind,
  output logic busy_det,
  output logic reorder_det,
  output logic answer_det,
  output logic compat_det,
  output logic digits_done,
  output logic hangup_note
);
  logic [15:0] cnt;
  logic [15:0] rcnt;
  logic dialed;
  logic ring;

  // Counts seizure time and time since the digits went out.
  always_ff @(posedge aclk) begin
    cnt <= off_hook ? cnt + 16'h0001 : 16'h0000;
    dialed <= off_hook && (dialed || addr_en);
    rcnt <= ring ? rcnt + 16'h0001 : 16'h0000;
  end

  // Office signals come a little after seizure; progress tones later.
  assign ring = dialed && !addr_en && off_hook;
  assign dial_tone = off_hook && cnt >= 16'h0005;
  assign gs_ind = dial_tone;
  assign digits_done = addr_en;
  assign busy_det = ring && mode == 3'h0 && rcnt >= 16'h0004;
  assign reorder_det = ring && mode == 3'h4 && rcnt >= 16'h0004;
  assign answer_det = ring && mode inside {3'h1, 3'h2} && rcnt >= 16'h0004;
  assign compat_det = answer_det && mode == 3'h1;
  assign hangup_note = answer_det && rcnt >= 16'h000c;
endmodule

// ===== testbench/tb.sv
// Self-checking bench of the auto dialer retry guard over AXI4-Lite.
// Assumes the design files and the line model are compiled first.
`timescale 1ns/1ps
`include "adrg_map.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  error_cnt++; $display("wrong value at %0t: %h expected %h", \
  $time, g, e); end end
module tb;
  localparam int MSC = 4;
  localparam int LKM = 100;
  localparam int NAM = 700;
  localparam logic [7:0] A_C = `ADRG_OFF_CTRL;
  localparam logic [7:0] A_S = `ADRG_OFF_STATUS;
  localparam logic [7:0] A_I = `ADRG_OFF_IRQ_STAT;
  localparam logic [7:0] A_M = `ADRG_OFF_IRQ_MASK;
  localparam logic [1:0] OK = `ADRG_RESP_OKAY;
  localparam logic [1:0] ERR = `ADRG_RESP_SLVERR;
  logic aclk;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, ext_reactivate = 1'b0;
  logic [2:0] mode = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, off_hook, addr_en;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic dial_tone, gs_ind, busy_det, reorder_det, answer_det, compat_det;
  logic digits_done, hangup_note, st;
  logic [31:0] cfg = 32'h0;
  int error_cnt = 0;
  int cmp_count = 0;
  int cyc = 0;
  int t_hk, t_dt, t_ad, t_rg, t_dn, t_hu;

  adrg_top #(.MS_CYCLES(MSC), .LOCK_MS(LKM), .NOANS_MS(NAM)) uut (.*);
  adrg_line line (.*);

  // Clock of 50 ns and a cycle count stepped away from the active edge.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  always @(negedge aclk) cyc++;

  // Time stamps of line events.
  always @(posedge off_hook) t_hk = cyc;
  always @(posedge dial_tone) t_dt = cyc;
  always @(posedge addr_en) t_ad = cyc;
  always @(negedge addr_en) t_rg = cyc;
  always @(negedge off_hook) t_dn = cyc;
  always @(posedge hangup_note) t_hu = cyc;

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = awvalid && awready;
      hw = wvalid && wready;
      hb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    `CHK(r, er)
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] er);
    logic ha, hb;
    logic [1:0] r;
    logic [31:0] d;
    hb = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hb) begin
      @(negedge aclk);
      ha = arvalid && arready;
      hb = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    `CHK(d & m, e)
    `CHK(r, er)
  endtask

  // Sets the stored controls; react also clears the guard.
  task automatic setcfg(input logic [31:0] v);
    cfg = v;
    wr(A_C, v, OK);
  endtask
  task automatic react();
    wr(A_C, cfg | 32'h2, OK);
  endtask

  // One attempt: st tells whether the line was seized at all.
  task automatic call(input logic [2:0] md);
    int n;
    n = 0;
    st = 1'b0;
    @(posedge aclk);
    mode <= md;
    wr(A_C, cfg | 32'h1, OK);
    while (!st && n < 20) begin
      @(negedge aclk);
      st = off_hook;
      n++;
    end
    while (off_hook) begin
      @(negedge aclk);
      n++;
    end
  endtask

  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Hang guard reckoned well above the expected run of some 46000 cycles.
  initial begin
    repeat (60000) @(posedge aclk);
    error_cnt++;
    summarize();
  end

  // Main sequence.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_C, 32'hffffffff, 32'h0, OK);
    rd(A_S, 32'h00003f7f, 32'h00000100, OK);
    rd(A_M, 32'hffffffff, 32'h0, OK);
    rd(8'h10, 32'hffffffff, 32'h0, ERR);
    wr(8'h10, 32'hffffffff, ERR);
    wr(A_C, 32'h000000fc, OK);
    rd(A_C, 32'hffffffff, 32'h000000fc, OK);
    wr(A_S, 32'hffffffff, OK);
    rd(A_S, 32'h00003f00, 32'h00000100, OK);
    $display("test registers done");
    setcfg(32'h20);
    repeat (2) begin
      call(3'h0);
      `CHK(st, 1'b1)
      `CHK((t_ad - t_dt) inside {[280:290]}, 1'b1)
    end
    rd(A_I, 32'h1, 32'h1, OK);
    `CHK(irq, 1'b0)
    call(3'h0);
    `CHK(st, 1'b0)
    rd(A_S, 32'h1f, 32'h12, OK);
    rd(A_I, 32'ha, 32'ha, OK);
    wr(A_M, 32'hf, OK);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b1)
    wr(A_I, 32'hf, OK);
    rd(A_I, 32'hf, 32'h0, OK);
    `CHK(irq, 1'b0)
    wr(A_M, 32'h0, OK);
    ext_reactivate <= 1'b1;
    @(posedge aclk);
    ext_reactivate <= 1'b0;
    rd(A_S, 32'h1f, 32'h0, OK);
    call(3'h0);
    `CHK(st, 1'b1)
    $display("test lockout done");
    setcfg(32'h30);
    react();
    for (int i = 0; i < 16; i++) begin
      call(i[0] ? 3'h4 : 3'h0);
      `CHK(st, i < 15)
      if (st) `CHK((t_dn - t_rg) <= 10, 1'b1)
    end
    react();
    call(3'h0);
    call(3'h3);
    `CHK((t_dn - t_rg) <= NAM * MSC + 4, 1'b1)
    call(3'h0);
    `CHK(st, 1'b0)
    $display("test extended limit done");
    setcfg(32'h0);
    react();
    call(3'h3);
    `CHK((t_ad - t_hk) inside {[2400:2410]}, 1'b1)
    setcfg(32'h40);
    call(3'h0);
    `CHK((t_ad - t_dt) inside {[280:290]}, 1'b1)
    repeat (LKM * MSC - 40) @(posedge aclk);
    rd(A_S, 32'h1f, 32'h12, OK);
    repeat (40) @(posedge aclk);
    rd(A_S, 32'h1f, 32'h0, OK);
    $display("test addressing delay done");
    setcfg(32'h20);
    react();
    repeat (2) begin
      call(3'h2);
      `CHK(st, 1'b1)
      `CHK((t_dn - t_hu) <= 2, 1'b1)
    end
    call(3'h2);
    `CHK(st, 1'b0)
    rd(A_S, 32'h20, 32'h20, OK);
    $display("test incompatible answer done");
    for (int k = 0; k < 2; k++) begin
      setcfg(k ? 32'h28 : 32'h24);
      repeat (3) begin
        call(3'h0);
        `CHK(st, 1'b1)
      end
    end
    wr(A_C, cfg | 32'h1, OK);
    repeat (3) @(posedge aclk);
    `CHK(off_hook, 1'b1)
    wr(A_C, cfg | 32'h200, OK);
    `CHK(off_hook, 1'b0)
    $display("test bypass modes done");
    setcfg(32'ha0);
    react();
    call(3'h1);
    call(3'h1);
    `CHK(st, 1'b0)
    wr(A_C, cfg | 32'h100, OK);
    call(3'h1);
    `CHK(st, 1'b1)
    $display("test sequential done");
    summarize();
  end
endmodule
